// [design/primary_bus_hold_and_control.sv]
`timescale 1ns/1ps
module primary_bus_hold_and_control (
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    input  wire logic                    reset_n_pin,
    input  wire logic                    shutdown_float_n,
    input  wire logic                    bus_release_request_n,
    input  wire logic                    release_inhibit_bit,
    input  wire logic                    transfer_ready_in_n,
    input  wire logic                    ack_instr,
    input  wire bus_ctrl_pkg::bus_req_t  core_req,
    output bus_ctrl_pkg::bus_rsp_t       core_rsp,
    output logic                         core_req_ready,
    output logic                         vector_fetch,
    output logic [23:0]                  bus_addr_out,
    output logic [31:0]                  bus_data_out,
    input  wire logic [31:0]             bus_data_in,
    output logic                         read_not_write,
    output logic                         access_strobe_n,
    output logic                         bus_release_grant,
    output logic                         intr_service_marker,
    output bus_ctrl_pkg::pin_oe_t        pin_oe
);
    import bus_ctrl_pkg::*;

    bus_state_t  state_q;
    bus_state_t  state_d;
    logic [23:0] addr_q;
    logic [31:0] wdata_q;
    logic        rnw_q;
    logic        strobe_n_q;
    logic        grant_q;
    logic        rsp_done_q;
    logic [31:0] rsp_data_q;
    logic        vector_q;
    pin_oe_t     oe_q;
    pin_oe_t     oe_d;
    logic        marker_n;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire in_reset   = ~reset_n_pin;
    wire shut       = ~shutdown_float_n;
    wire hold_want  = ~bus_release_request_n & ~release_inhibit_bit;
    wire rdy        = ~transfer_ready_in_n;
    wire acc_done   = (state_q == ST_ACCESS || state_q == ST_VECTOR) & rdy;
    wire start_ok   = (state_q == ST_IDLE) & ~hold_want & core_req.valid;
    wire released   = (state_q == ST_RELEASED);

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET:    state_d = ST_VECTOR;
            ST_VECTOR:   state_d = rdy ? ST_IDLE : ST_VECTOR;
            ST_IDLE: begin
                if (hold_want) begin
                    state_d = ST_RELEASED;
                end else if (core_req.valid) begin
                    state_d = ST_ACCESS;
                end
            end
            // Release waits for the running access to end
            ST_ACCESS:   state_d = rdy ? ST_IDLE : ST_ACCESS;
            ST_RELEASED: state_d = hold_want ? ST_RELEASED : ST_IDLE;
            default:     state_d = ST_RESET;
        endcase
        if (in_reset || shut) begin
            state_d = ST_RESET;
        end
    end

    // Float conditions per pin group
    always_comb begin
        oe_d             = '0;
        oe_d.addr_oe_n   = shut | released | in_reset;
        oe_d.data_oe_n   = shut | released | in_reset | rnw_q;
        oe_d.rnw_oe_n    = shut | released | in_reset;
        oe_d.strobe_oe_n = shut | released;
        oe_d.grant_oe_n  = shut;
        oe_d.marker_oe_n = shut;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_RESET;
            oe_q    <= '1;
        end else begin
            state_q <= state_d;
            oe_q    <= oe_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            addr_q     <= ADDR_RST;
            wdata_q    <= DATA_RST;
            rnw_q      <= 1'b1;
            strobe_n_q <= 1'b1;
            grant_q    <= 1'b1;
            rsp_done_q <= 1'b0;
            rsp_data_q <= DATA_RST;
            vector_q   <= 1'b0;
        end else begin
            rsp_done_q <= acc_done & (state_q == ST_ACCESS);
            vector_q   <= acc_done & (state_q == ST_VECTOR);
            if (acc_done) begin
                rsp_data_q <= bus_data_in;
            end
            if (state_q == ST_RESET && !in_reset && !shut) begin
                addr_q <= RESET_VECTOR_ADDR;
                rnw_q  <= 1'b1;
            end else if (start_ok) begin
                addr_q  <= core_req.addr;
                wdata_q <= core_req.wdata;
                rnw_q   <= ~core_req.write;
            end
            // Strobe low from launch until ready
            strobe_n_q <= ~((state_d == ST_ACCESS) | (state_d == ST_VECTOR));
            // Grant only once the pins are already floating
            grant_q    <= ~(released & hold_want & oe_q.addr_oe_n);
        end
    end

    marker_pulse u_marker (
        .core_clk  (core_clk),
        .reset     (reset),
        .ack_instr (ack_instr & ~shut),
        .marker_n  (marker_n)
    );

    sync_flop #(.W(1), .RST(1'b1)) u_marker_q (
        .core_clk (core_clk),
        .reset    (reset),
        .d        (marker_n),
        .q        (intr_service_marker)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus_addr_out      = addr_q;
    assign bus_data_out      = wdata_q;
    assign read_not_write    = rnw_q;
    assign access_strobe_n   = strobe_n_q;
    assign bus_release_grant = grant_q;
    assign core_rsp          = '{done: rsp_done_q, rdata: rsp_data_q};
    assign vector_fetch      = vector_q;
    assign pin_oe            = oe_q;
    assign core_req_ready    = rsp_done_q;
endmodule : primary_bus_hold_and_control

// [design/bus_ctrl_pkg.sv]
// How it works
// - Read/write line is high for the whole of a read and low for the whole of a write.
// - A release request lets any access already under way finish first.
// - While released, address, data, strobe and read/write all float.
// - No new access starts until the request goes away or the inhibit bit is set.
// - Grant goes low only after the bus floats and all accesses are held.
// - Grant returns high when the request ends or the inhibit bit is set, then the bus is driven again.
// - The device stays in reset while the active-low reset input is low.
// - On leaving reset the first fetch reads the reset vector location.
// - The service marker pulses low for one cycle each time the acknowledge instruction runs.
// - Under shutdown the block stops and every pin floats.
// - Data, address, read/write float under shutdown, release or reset, data also for reads; strobe under shutdown or release; grant and marker only under shutdown.
package bus_ctrl_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam logic [23:0] RESET_VECTOR_ADDR = 24'h000000;
    localparam logic [23:0] ADDR_RST          = 24'h000000;
    localparam logic [31:0] DATA_RST          = 32'h00000000;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [23:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic        done;
        logic [31:0] rdata;
    } bus_rsp_t;

    // Output enables are active low: 0 means driven
    typedef struct packed {
        logic addr_oe_n;
        logic data_oe_n;
        logic rnw_oe_n;
        logic strobe_oe_n;
        logic grant_oe_n;
        logic marker_oe_n;
    } pin_oe_t;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_VECTOR,
        ST_IDLE,
        ST_ACCESS,
        ST_RELEASED
    } bus_state_t;
endpackage : bus_ctrl_pkg

// [design/sync_flop.sv]
`timescale 1ns/1ps
// Reset-able register used for the service marker pin
module sync_flop #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end
endmodule : sync_flop

// [design/marker_pulse.sv]
`timescale 1ns/1ps
// One-cycle active-low pulse per acknowledge instruction
module marker_pulse (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic ack_instr,
    output logic      marker_n
);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            marker_n <= 1'b1;
        end else begin
            marker_n <= ~ack_instr;
        end
    end
endmodule : marker_pulse

// [verification/bus_ctrl_checker.sv]
`timescale 1ns/1ps
module bus_ctrl_checker (
    input wire logic core_clk, reset, reset_n_pin, shutdown_float_n, ack_instr,
    input wire logic bus_release_request_n, release_inhibit_bit, transfer_ready_in_n,
    input wire logic core_req_ready, vector_fetch, access_strobe_n, read_not_write,
    input wire logic bus_release_grant, intr_service_marker,
    input wire bus_ctrl_pkg::bus_req_t core_req,
    input wire bus_ctrl_pkg::bus_rsp_t core_rsp,
    input wire bus_ctrl_pkg::pin_oe_t  pin_oe
);
    import bus_ctrl_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_dir;
        $fell(access_strobe_n) && core_req.valid |-> read_not_write == !core_req.write;
    endproperty
    a_dir: assert property (p_dir) else $error("bad direction");
    property p_wait;
        !access_strobe_n && transfer_ready_in_n && !pin_oe.strobe_oe_n |=> !access_strobe_n;
    endproperty
    a_wait: assert property (p_wait) else $error("strobe left early");
    property p_end;
        !access_strobe_n && !transfer_ready_in_n |=> access_strobe_n
            && (core_rsp.done || vector_fetch) && core_req_ready == core_rsp.done;
    endproperty
    a_end: assert property (p_end) else $error("access did not end");
    property p_float; !bus_release_grant && !pin_oe.grant_oe_n |-> &pin_oe[5:2]; endproperty
    a_float: assert property (p_float) else $error("bus driven in hold");
    property p_grant;
        $fell(bus_release_grant) |-> $past(pin_oe.strobe_oe_n) && !bus_release_request_n;
    endproperty
    a_grant: assert property (p_grant) else $error("early grant");
    property p_back;
        !bus_release_grant && (bus_release_request_n || release_inhibit_bit)
            |-> ##[1:2] bus_release_grant;
    endproperty
    a_back: assert property (p_back) else $error("grant stuck");
    property p_rst;
        !reset_n_pin && $past(!reset_n_pin) && !$past(reset) && shutdown_float_n
            |-> pin_oe.addr_oe_n && pin_oe.rnw_oe_n && !pin_oe.strobe_oe_n && access_strobe_n;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset pins");
    property p_mark; ack_instr |-> ##2 !intr_service_marker; endproperty
    a_mark: assert property (p_mark) else $error("no marker");
    property p_shz; !shutdown_float_n && $past(!shutdown_float_n) |-> &pin_oe; endproperty
    a_shz: assert property (p_shz) else $error("pin driven in shutdown");
    c_grant: cover property (!bus_release_grant);
    c_wait: cover property (!access_strobe_n && transfer_ready_in_n);
    c_mark: cover property ($fell(intr_service_marker));
endmodule : bus_ctrl_checker

bind primary_bus_hold_and_control bus_ctrl_checker chk (.*);

// [verification/ext_memory_model.sv]
`timescale 1ns/1ps
module ext_memory_model (
    input  wire logic        core_clk,
    input  wire logic        access_strobe_n,
    input  wire logic        read_not_write,
    input  wire logic [23:0] bus_addr_out,
    input  wire logic [3:0]  wait_cycles,
    output logic             transfer_ready_in_n,
    output logic      [31:0] bus_data_in
);
    logic [3:0] cnt_q;
    always_ff @(posedge core_clk) begin
        cnt_q <= access_strobe_n ? 4'h0 : cnt_q + 4'h1;
    end
    assign transfer_ready_in_n = access_strobe_n | (cnt_q < wait_cycles);
    // Undriven data lines show the inverse, never a held word
    assign bus_data_in = {8'ha5, bus_addr_out} ^ {32{access_strobe_n | !read_not_write}};
endmodule : ext_memory_model

// [verification/primary_bus_hold_and_control_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch at %0t: value differs", $time); end end
module primary_bus_hold_and_control_tb;
    import bus_ctrl_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, reset_n_pin = 1'b0, shutdown_float_n = 1'b1;
    logic bus_release_request_n = 1'b1, release_inhibit_bit = 1'b0, ack_instr = 1'b0;
    logic transfer_ready_in_n, core_req_ready, vector_fetch, read_not_write;
    logic access_strobe_n, bus_release_grant, intr_service_marker;
    logic [23:0] bus_addr_out;
    logic [31:0] bus_data_out, bus_data_in;
    logic [3:0]  wait_cycles = 4'h0;
    bus_req_t    core_req = '0;
    bus_rsp_t    core_rsp;
    pin_oe_t     pin_oe;
    int          fail_count = 0, samples_checked = 0, cycles = 0, n;
    primary_bus_hold_and_control uut (.*);
    ext_memory_model mem (.*);
    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            results();
        end
    end
    task results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    task access(input logic wr, input logic [23:0] a, input logic [31:0] d);
        @(negedge core_clk);
        core_req = '{1'b1, wr, a, d};
        for (n = 0; n < 40 && core_rsp.done !== 1'b1; n++) @(negedge core_clk);
        `CHK({core_rsp.done, read_not_write}, {1'b1, ~wr})
        `CHK(wr ? bus_data_out : core_rsp.rdata, wr ? d : {8'ha5, a})
        core_req.valid = 1'b0;
    endtask : access
    task t_boot();
        repeat (2) @(negedge core_clk);
        `CHK({pin_oe.addr_oe_n, pin_oe.strobe_oe_n, access_strobe_n}, 3'b101)
        reset_n_pin = 1'b1;
        for (n = 0; n < 40 && vector_fetch !== 1'b1; n++) @(negedge core_clk);
        `CHK(core_rsp.rdata, {8'ha5, RESET_VECTOR_ADDR})
    endtask : t_boot
    task t_hold();
        wait_cycles = 4'h6;
        fork
            access(1'b0, 24'h000100, 32'h0);
            begin
                repeat (3) @(negedge core_clk);
                bus_release_request_n = 1'b0;
            end
        join
        repeat (4) @(negedge core_clk);
        // Another master may drive the shared lines only from here on
        `CHK({bus_release_grant, pin_oe[5:2]}, 5'h0f)
        core_req = '{1'b1, 1'b0, 24'h000200, 32'h0};
        repeat (5) @(negedge core_clk);
        `CHK(core_rsp.done, 1'b0)
        release_inhibit_bit = 1'b1;
        access(1'b0, 24'h000200, 32'h0);
        `CHK(bus_release_grant, 1'b1)
        bus_release_request_n = 1'b1;
        release_inhibit_bit = 1'b0;
    endtask : t_hold
    task t_marker();
        @(negedge core_clk);
        ack_instr = 1'b1;
        @(negedge core_clk);
        ack_instr = 1'b0;
        @(negedge core_clk);
        `CHK(intr_service_marker, 1'b0)
        @(negedge core_clk);
        `CHK(intr_service_marker, 1'b1)
    endtask : t_marker
    initial begin
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        t_boot();
        access(1'b1, 24'hfffffe, 32'h5a5a0001);
        wait_cycles = 4'h3;
        access(1'b0, 24'h00abcd, 32'h0);
        t_hold();
        t_marker();
        shutdown_float_n = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK(pin_oe, 6'h3f)
        reset = 1'b1;
        reset_n_pin = 1'b0;
        shutdown_float_n = 1'b1;
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        t_boot();
        results();
    end
endmodule : primary_bus_hold_and_control_tb
